/* File: logic/ewp_core.sv */
// serial eeprom write-enable latch, status register and write protection
`timescale 1ns/10ps
`include "ewp_defs.svh"
module ewp_core #(
  parameter int WRITE_CYCLE_CYC = `EWP_TWC_NS / `EWP_CLK_NS,
  parameter int PAGE_BYTES = `EWP_PAGE_BYTES
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic prog_start_o,
  output ewp_pkg::ewp_cyc_t prog_kind_o,
  output logic [10:0] prog_addr_o,
  output logic [5:0] prog_nbytes_o,
  output logic busy_o,
  output logic [7:0] status_o
);
  import ewp_pkg::*;
  // the array itself lives outside this block: an accepted write leaves as a
  // one-cycle request on the prog ports and the array side programs it. a page
  // write wraps inside its page and pages never straddle a protection boundary,
  // so judging protection on the start address alone is safe.

  localparam int CW = $clog2(WRITE_CYCLE_CYC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(WRITE_CYCLE_CYC - 1);
  localparam logic [9:0] MAX_WR_BITS = 10'(24 + 8 * PAGE_BYTES);

  if (WRITE_CYCLE_CYC < 1) begin : g_bad_cyc
    $error("write cycle count must be at least one");
  end
  if (PAGE_BYTES < 1 || PAGE_BYTES > 32) begin : g_bad_page
    $error("page size must lie between 1 and 32 bytes");
  end
  // the bit counter wraps for long status reads; the longest write must end below that
  if (`EWP_HDR_BITS + 8 * PAGE_BYTES >= `EWP_CNT_WRAP) begin : g_bad_wrap
    $error("page size reaches the bit counter wrap point");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // each pin costs about four core cycles; every sck phase must last at least
  // two core cycles or the agreement filter swallows it
  logic cs_n_q;
  logic sck_q;
  logic si_q;
  logic wp_n_q;

  // select resets low so a pin already low at reset never looks like a fall
  ewp_pin_sync #(.RST_VAL(1'b0)) u_sync_cs (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(cs_n_i),
    .level_o(cs_n_q)
  );
  ewp_pin_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(sck_i),
    .level_o(sck_q)
  );
  ewp_pin_sync #(.RST_VAL(1'b0)) u_sync_si (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(si_i),
    .level_o(si_q)
  );
  ewp_pin_sync #(.RST_VAL(1'b1)) u_sync_wp (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(wp_n_i),
    .level_o(wp_n_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and frame tracking
  logic cs_prev_ff;
  logic sck_prev_ff;
  logic frame_ff;

  wire cs_fall = cs_prev_ff & ~cs_n_q;
  wire cs_rise = ~cs_prev_ff & cs_n_q;
  wire sck_rise = frame_ff & ~sck_prev_ff & sck_q;
  wire sck_fall = frame_ff & sck_prev_ff & ~sck_q;
  wire frame_end = frame_ff & cs_rise;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_prev_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
    end else begin
      cs_prev_ff <= cs_n_q;
      sck_prev_ff <= sck_q;
    end
  end

  // only a seen high-to-low select opens a frame [RQ16]
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      frame_ff <= 1'b0;
    end else if (cs_fall) begin
      frame_ff <= 1'b1;
    end else if (cs_rise) begin
      frame_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive side: bits shift in on rising serial clock, msb first
  logic [9:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [10:0] addr_ff;
  logic [2:0] sr_data_ff;
  ewp_op_t op_ff;

  wire [7:0] nxt_rx = {rx_ff[6:0], si_q}; // [RQ19] [RQ21]
  // a long status read wraps the counter inside its byte phase
  wire [9:0] nxt_bit_cnt = (bit_cnt_ff == `EWP_CNT_TOP) ? `EWP_CNT_WRAP : bit_cnt_ff + 10'h001;
  wire addr_phase = (bit_cnt_ff >= `EWP_OP_BITS) && (bit_cnt_ff < `EWP_HDR_BITS);

  // the array read opcode is only recognised; no array data leaves this block
  ewp_op_t op_dec;
  always_comb begin
    unique case (nxt_rx)
      `EWP_OP_LATCH_SET: op_dec = EWP_OP_SET_LATCH; // [RQ20]
      `EWP_OP_LATCH_CLR: op_dec = EWP_OP_CLR_LATCH; // [RQ20]
      `EWP_OP_SR_RD: op_dec = EWP_OP_SR_READ;
      `EWP_OP_SR_WR: op_dec = EWP_OP_SR_WRITE;
      `EWP_OP_WRITE: op_dec = EWP_OP_ARR_WRITE;
      `EWP_OP_READ: op_dec = EWP_OP_ARR_READ;
      default: op_dec = EWP_OP_NONE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || cs_fall) begin
      bit_cnt_ff <= 10'h000;
    end else if (sck_rise) begin
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_ff <= 8'h00;
    end else if (sck_rise) begin
      rx_ff <= nxt_rx;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || cs_fall) begin
      op_ff <= EWP_OP_NONE;
    end else if (sck_rise && bit_cnt_ff == `EWP_OP_BITS - 10'h001) begin
      op_ff <= op_dec;
    end
  end

  // upper five address bits fall off the 11-bit shifter
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      addr_ff <= 11'h000;
    end else if (sck_rise && addr_phase) begin
      addr_ff <= {addr_ff[9:0], si_q}; // [RQ21]
    end
  end

  // only the three nonvolatile positions of the written byte are kept [RQ9]
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sr_data_ff <= 3'h0;
    end else if (sck_rise && bit_cnt_ff == `EWP_SRW_BITS - 10'h001) begin
      sr_data_ff <= {nxt_rx[`EWP_SR_PIN_EN], nxt_rx[`EWP_SR_BP_HI], nxt_rx[`EWP_SR_BP_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection and commit decisions at the select rise
  logic latch_ff;
  logic busy_ff;
  logic pin_en_ff;
  logic bp_hi_ff;
  logic bp_lo_ff;

  wire hw_prot = pin_en_ff & ~wp_n_q; // [RQ11]
  wire [1:0] bp_sel = {bp_hi_ff, bp_lo_ff};
  wire prot_quarter = (bp_sel == 2'h1) && (addr_ff >= `EWP_PROT_QUARTER);
  wire prot_half = (bp_sel == 2'h2) && (addr_ff >= `EWP_PROT_HALF);
  wire blk_prot = prot_quarter | prot_half | (bp_sel == 2'h3); // [RQ10]

  wire len_op = (bit_cnt_ff == `EWP_OP_BITS);
  wire len_sr = (bit_cnt_ff == `EWP_SRW_BITS);
  // whole data bytes only, at least one, no more than one page [RQ14]
  wire len_wr = (bit_cnt_ff >= `EWP_MIN_WR_BITS) && (bit_cnt_ff[2:0] == 3'h0)
                && (bit_cnt_ff <= MAX_WR_BITS);

  // a busy device ignores everything but status reads [RQ15] [RQ5]
  // busy also blocks latch set, so a frame sent mid-cycle cannot arm the next write
  wire commit_ok = frame_end & ~busy_ff;
  wire do_set = commit_ok && op_ff == EWP_OP_SET_LATCH && len_op; // [RQ2] [RQ8]
  wire do_clr = commit_ok && op_ff == EWP_OP_CLR_LATCH && len_op; // [RQ2] [RQ8]
  wire do_srw = commit_ok && op_ff == EWP_OP_SR_WRITE && len_sr
                && latch_ff && !hw_prot; // [RQ1] [RQ12] [RQ14]
  wire do_arw = commit_ok && op_ff == EWP_OP_ARR_WRITE && len_wr
                && latch_ff && !blk_prot; // [RQ1] [RQ10] [RQ14]
  wire start_cyc = do_srw | do_arw;
  wire [9:0] data_bits = bit_cnt_ff - `EWP_HDR_BITS;

  // refused writes leave the latch alone; only executed ones clear it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      latch_ff <= 1'b0; // [RQ3] [RQ16]
    end else if (do_set) begin
      latch_ff <= 1'b1; // [RQ2]
    end else if (do_clr || start_cyc) begin
      latch_ff <= 1'b0; // [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal write cycle timer
  logic [CW-1:0] cyc_cnt_ff;
  ewp_cyc_t cyc_kind_ff;
  logic [2:0] nv_pend_ff;

  // loading the last index keeps busy high for exactly WRITE_CYCLE_CYC cycles
  wire cyc_done = busy_ff && (cyc_cnt_ff == '0);

  // the protect pin is judged only at the start, so later changes cannot
  // reach a cycle in flight; select is not looked at here at all [RQ13] [RQ17]
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      busy_ff <= 1'b0;
      cyc_cnt_ff <= '0;
      cyc_kind_ff <= EWP_CYC_NONE;
      nv_pend_ff <= 3'h0;
    end else if (start_cyc) begin
      busy_ff <= 1'b1; // [RQ7]
      cyc_cnt_ff <= CYC_LAST;
      cyc_kind_ff <= do_srw ? EWP_CYC_STATUS : EWP_CYC_ARRAY;
      nv_pend_ff <= sr_data_ff;
    end else if (cyc_done) begin
      busy_ff <= 1'b0; // [RQ7]
      cyc_kind_ff <= EWP_CYC_NONE;
    end else if (busy_ff) begin
      cyc_cnt_ff <= cyc_cnt_ff - CW'(1); // [RQ15]
    end
  end

  // nonvolatile bits skip the reset so they survive it like a power loss;
  // the initial value stands in for the factory state [RQ9]
  logic [2:0] nv_ff = `EWP_NV_RESET;
  always_ff @(posedge core_clk_i) begin
    if (cyc_done && cyc_kind_ff == EWP_CYC_STATUS) begin
      nv_ff <= nv_pend_ff; // [RQ9]
    end
  end
  assign pin_en_ff = nv_ff[2];
  assign bp_hi_ff = nv_ff[1];
  assign bp_lo_ff = nv_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // status byte, undefined bits read as zero
  wire [7:0] status_cur = {pin_en_ff, 3'h0, bp_hi_ff, bp_lo_ff, latch_ff, busy_ff}; // [RQ6] [RQ8]

  ////////////////////////////////////////////////////////////////////////////
  // transmit side: output changes after the falling serial clock
  logic so_ff;
  logic so_oe_n_ff;
  logic [7:0] tx_ff;

  // re-sampling at each byte start lets a poll see busy drop within one frame
  wire sr_out = sck_fall && op_ff == EWP_OP_SR_READ && bit_cnt_ff >= `EWP_OP_BITS;
  wire byte_start = (bit_cnt_ff[2:0] == 3'h0);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      so_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (sr_out && byte_start) begin
      so_ff <= status_cur[7]; // [RQ23] [RQ19] [RQ5]
      tx_ff <= {status_cur[6:0], 1'b0};
    end else if (sr_out) begin
      so_ff <= tx_ff[7]; // [RQ21]
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // enable is active low; released the moment select rises
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !frame_ff || cs_rise) begin
      so_oe_n_ff <= 1'b1; // [RQ18] [RQ16]
    end else if (sr_out) begin
      so_oe_n_ff <= 1'b0; // [RQ23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming request to the array side and mirrored status
  // prog_start_o is one cycle wide; the array side must take it on that edge
  logic prog_start_ff;
  ewp_cyc_t prog_kind_ff;
  logic [10:0] prog_addr_ff;
  logic [5:0] prog_nbytes_ff;
  logic [7:0] status_ff;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prog_start_ff <= 1'b0;
      prog_kind_ff <= EWP_CYC_NONE;
      prog_addr_ff <= 11'h000;
      prog_nbytes_ff <= 6'h00;
    end else begin
      prog_start_ff <= start_cyc; // [RQ14]
      if (start_cyc) begin
        prog_kind_ff <= do_srw ? EWP_CYC_STATUS : EWP_CYC_ARRAY;
        prog_addr_ff <= do_srw ? 11'h000 : addr_ff;
        prog_nbytes_ff <= do_srw ? 6'h01 : data_bits[8:3];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= status_cur;
    end
  end

  assign so_o = so_ff;
  assign so_oe_n_o = so_oe_n_ff;
  assign prog_start_o = prog_start_ff;
  assign prog_kind_o = prog_kind_ff;
  assign prog_addr_o = prog_addr_ff;
  assign prog_nbytes_o = prog_nbytes_ff;
  assign busy_o = busy_ff;
  assign status_o = status_ff;

endmodule

/* File: logic/ewp_defs.svh */
// constants for the eeprom write-enable, status and protection block
// Summary of operation
// (RQ1) array or status writes complete only while the write enable latch is set
// (RQ2) latch-set instruction sets the latch, latch-clear instruction clears it
// (RQ3) latch clears at power-up and after latch-clear, status write or array write
// (RQ4) master issues latch-set in its own select frame before every write
// (RQ5) status byte can be read at any time, even during a write cycle
// (RQ6) status: bit7 pin enable, bits3/2 block protect, bit1 latch, bit0 busy
// (RQ7) busy bit is 1 during an internal write cycle, writes to it ignored
// (RQ8) latch bit mirrors latch, set/clear works regardless of status protection
// (RQ9) status write changes only pin enable and block protect, kept without power
// (RQ10) protect pair: none, 600h-7FFh, 400h-7FFh, whole array; protected writes dropped
// (RQ11) hardware protection only when protect pin low and pin enable set
// (RQ12) hardware protection blocks only nonvolatile status writes
// (RQ13) protect pin going low never alters a write cycle already started
// (RQ14) write cycle starts only when select rises after an exact valid length
// (RQ15) array access during a write cycle is ignored, programming continues
// (RQ16) after power-up serial output is off and a select fall is required first
// (RQ17) select rising during a write cycle does not stop it
// (RQ18) serial output is high impedance while select is high
// (RQ19) input sampled on rising clock edge, output changes after falling edge
// (RQ20) opcode 06h sets latch, 04h clears it, each a lone 8-bit instruction
// (RQ21) all instruction, address and data bits travel most significant first
// (RQ22) master raises select only after the last data bit is clocked in
// (RQ23) after the status read opcode the status byte repeats while selected
`ifndef EWP_DEFS_SVH
`define EWP_DEFS_SVH

`define EWP_OP_SR_WR 8'h01
`define EWP_OP_WRITE 8'h02
`define EWP_OP_READ 8'h03
`define EWP_OP_LATCH_CLR 8'h04
`define EWP_OP_SR_RD 8'h05
`define EWP_OP_LATCH_SET 8'h06

`define EWP_SR_PIN_EN 7
`define EWP_SR_BP_HI 3
`define EWP_SR_BP_LO 2
`define EWP_SR_LATCH 1
`define EWP_SR_BUSY 0

`define EWP_NV_RESET 3'h0
`define EWP_PROT_QUARTER 11'h600
`define EWP_PROT_HALF 11'h400

`define EWP_OP_BITS 10'h008
`define EWP_SRW_BITS 10'h010
`define EWP_HDR_BITS 10'h018
`define EWP_MIN_WR_BITS 10'h020
`define EWP_CNT_TOP 10'h3FF
`define EWP_CNT_WRAP 10'h3F8

`define EWP_TWC_NS 5000000
`define EWP_CLK_NS 20
`define EWP_PAGE_BYTES 32

`endif

/* File: logic/ewp_pkg.sv */
// types shared by the eeprom write-enable, status and protection block
package ewp_pkg;

  typedef enum logic [2:0] {
    EWP_OP_NONE,
    EWP_OP_SET_LATCH,
    EWP_OP_CLR_LATCH,
    EWP_OP_SR_READ,
    EWP_OP_SR_WRITE,
    EWP_OP_ARR_WRITE,
    EWP_OP_ARR_READ
  } ewp_op_t;

  typedef enum logic [1:0] {
    EWP_CYC_NONE,
    EWP_CYC_ARRAY,
    EWP_CYC_STATUS
  } ewp_cyc_t;

endpackage

/* File: logic/ewp_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ewp_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  wire agree = (s2_ff == s3_ff);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_o = level_ff;

endmodule

/* File: verif/ewp_spi_master.sv */
// spi bus master model driving the eeprom block's serial pins
`timescale 1ns/10ps
module ewp_spi_master (
  input wire logic core_clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask
  // sck rests low between frames; rx holds the last eight bits seen on so
  task automatic xfer(input logic [47:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge core_clk_i);
    cs_n_o = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      si_o = d[47 - i];
      half();
      sck_o = 1'b1;
      half();
      // so sampled late in the high phase, it only moves after the fall
      rx = {rx[6:0], so_i};
      sck_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (8) @(negedge core_clk_i);
  endtask
endmodule

/* File: verif/ewp_core_assertions.sv */
// concurrent checks on the ports of the eeprom protection block
`timescale 1ns/10ps
module ewp_core_assertions #(
  parameter int WRITE_CYCLE_CYC = 250000
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic prog_start_o,
  input wire ewp_pkg::ewp_cyc_t prog_kind_o,
  input wire logic [10:0] prog_addr_o,
  input wire logic [5:0] prog_nbytes_o,
  input wire logic busy_o,
  input wire logic [7:0] status_o
);
  import ewp_pkg::*;
  logic [3:0] desel_ff;
  logic [31:0] busy_len_ff;
  wire [1:0] bp = status_o[3:2];
  wire prot = (bp == 2'h3) || (bp == 2'h2 && prog_addr_o >= 11'h400) ||
    (bp == 2'h1 && prog_addr_o >= 11'h600);
  // long margin: the select pin passes a synchroniser before it counts
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !cs_n_i) desel_ff <= 4'h0;
    else if (desel_ff != 4'hF) desel_ff <= desel_ff + 4'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !busy_o) busy_len_ff <= 32'h0;
    else busy_len_ff <= busy_len_ff + 32'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  chk_so_off_desel: assert property (desel_ff == 4'hF |-> so_oe_n_o)
    else $error("serial output driven while deselected");
  chk_start_busy: assert property (prog_start_o == $rose(busy_o))
    else $error("write start and busy rise disagree");
  chk_busy_len: assert property ($fell(busy_o) |-> busy_len_ff == WRITE_CYCLE_CYC)
    else $error("write cycle length wrong");
  chk_busy_flag: assert property (status_o[0] == $past(busy_o))
    else $error("busy bit does not follow write cycle");
  chk_no_start_busy: assert property (prog_start_o |-> !$past(busy_o))
    else $error("write started during a write cycle");
  chk_start_latch: assert property (prog_start_o |-> $past(status_o[1]))
    else $error("write started with latch clear");
  chk_latch_clear: assert property (prog_start_o |=> !status_o[1])
    else $error("latch not cleared by write");
  chk_prot_range: assert property (prog_start_o && prog_kind_o == EWP_CYC_ARRAY |-> !prot)
    else $error("write started in protected range");
  chk_nv_hold: assert property ($changed({status_o[7], bp}) && !$past(srst_i) &&
    !$past(srst_i, 2) |-> $past(busy_o, 2) && !$past(busy_o))
    else $error("nonvolatile bits changed outside write end");
endmodule
bind ewp_core ewp_core_assertions #(.WRITE_CYCLE_CYC(WRITE_CYCLE_CYC)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
  .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
  .prog_start_o(prog_start_o), .prog_kind_o(prog_kind_o), .prog_addr_o(prog_addr_o),
  .prog_nbytes_o(prog_nbytes_o), .busy_o(busy_o), .status_o(status_o));

/* File: verif/test_ewp_core.sv */
// self-checking bench for the eeprom write-enable, status and protection block
`timescale 1ns/10ps
`include "ewp_defs.svh"
`define TB_EQ(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_ewp_core;
  import ewp_pkg::*;
  localparam int TWC = 400;
  logic clk, srst, wp_n, cs_n, sck, si, so, so_oe_n, start, busy;
  ewp_cyc_t kind;
  logic [10:0] addr;
  logic [5:0] nbytes;
  logic [7:0] status, rx;
  logic [10:0] al [6] = '{11'h000, 11'h3FF, 11'h400, 11'h5FF, 11'h600, 11'h7FF};
  int err_total = 0;
  int samples_checked = 0;
  int starts = 0;
  // released line shows the inverse so a stale bit never looks valid
  wire so_line = so_oe_n ? ~so : so;
  ewp_core #(.WRITE_CYCLE_CYC(TWC)) u_dut (.core_clk_i(clk), .srst_i(srst), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n),
    .prog_start_o(start), .prog_kind_o(kind), .prog_addr_o(addr), .prog_nbytes_o(nbytes),
    .busy_o(busy), .status_o(status));
  ewp_spi_master u_mst (.core_clk_i(clk), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si));
  always @(posedge clk) if (start === 1'b1) starts++;
  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame(input logic [47:0] d, input int n);
    u_mst.xfer(d, n, rx);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (4) @(negedge clk);
    while (busy !== 1'b0 && k < 2 * TWC) begin
      @(negedge clk);
      k++;
    end
    // status_o trails busy by one cycle
    repeat (2) @(negedge clk);
    `TB_EQ("idle", 1'b0, busy)
  endtask
  task automatic try_write(input logic [47:0] d, input int n, input int we, input int exp);
    int s0;
    if (we != 0) frame({`EWP_OP_LATCH_SET, 40'h0}, 8);
    s0 = starts;
    frame(d, n);
    wait_idle();
    `TB_EQ("start", exp, starts - s0)
  endtask
  task automatic srw(input logic [7:0] v, input int exp);
    try_write({`EWP_OP_SR_WR, v, 32'h0}, 16, 1, exp);
  endtask
  task automatic t_power_on();
    `TB_EQ("oe_n", 1'b1, so_oe_n)
    `TB_EQ("status", 8'h00, status)
  endtask
  task automatic t_latch();
    frame({`EWP_OP_LATCH_SET, 40'h0}, 8);
    frame({`EWP_OP_SR_RD, 40'h0}, 24);
    `TB_EQ("rd_latch", 8'h02, rx)
    frame({`EWP_OP_LATCH_CLR, 40'h0}, 8);
    `TB_EQ("latch_off", 1'b0, status[1])
  endtask
  task automatic t_refuse();
    try_write({`EWP_OP_SR_WR, 8'h8C, 32'h0}, 16, 0, 0);
    try_write({`EWP_OP_SR_WR, 8'h8C, 32'h0}, 15, 1, 0);
    `TB_EQ("latch_kept", 1'b1, status[1])
    try_write({`EWP_OP_WRITE, 24'h0, 16'h0}, 36, 1, 0);
  endtask
  task automatic t_status();
    frame({`EWP_OP_LATCH_SET, 40'h0}, 8);
    frame({`EWP_OP_SR_WR, 8'h8F, 32'h0}, 16);
    `TB_EQ("kind", EWP_CYC_STATUS, kind)
    `TB_EQ("sr_nbytes", 6'h01, nbytes)
    frame({`EWP_OP_SR_RD, 40'h0}, 16);
    `TB_EQ("rd_busy", 8'h01, rx)
    wait_idle();
    `TB_EQ("sr_new", 8'h8C, status)
    @(negedge clk);
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    `TB_EQ("sr_kept", 8'h8C, status)
  endtask
  task automatic t_bp();
    logic prot;
    for (int b = 0; b < 4; b++) begin
      srw({4'h0, b[1:0], 2'h0}, 1);
      `TB_EQ("bp", b[1:0], status[3:2])
      foreach (al[i]) begin
        prot = (b == 3) || (b == 2 && al[i] >= 11'h400) || (b == 1 && al[i] >= 11'h600);
        try_write({`EWP_OP_WRITE, 5'h00, al[i], 8'hA5, 16'h0}, 32, 1, !prot);
        if (!prot) `TB_EQ("addr", al[i], addr)
      end
    end
  endtask
  task automatic t_hw();
    int s0;
    srw(8'h80, 1);
    wp_n = 1'b0;
    srw(8'h00, 0);
    try_write({`EWP_OP_WRITE, 5'h00, 11'h7FF, 8'h5A, 16'h0}, 32, 1, 1);
    wp_n = 1'b1;
    frame({`EWP_OP_LATCH_SET, 40'h0}, 8);
    s0 = starts;
    frame({`EWP_OP_SR_WR, 8'h04, 32'h0}, 16);
    wp_n = 1'b0;
    wait_idle();
    `TB_EQ("hw_start", 1, starts - s0)
    `TB_EQ("hw_keep", 8'h04, status)
    srw(8'h00, 1);
    wp_n = 1'b1;
  endtask
  task automatic t_busy();
    int s0;
    frame({`EWP_OP_LATCH_SET, 40'h0}, 8);
    s0 = starts;
    frame({`EWP_OP_WRITE, 16'h0100, 16'h1122, 8'h0}, 40);
    `TB_EQ("nbytes", 6'h02, nbytes)
    // latch set sent mid-cycle must not arm the second write
    frame({`EWP_OP_LATCH_SET, 40'h0}, 8);
    frame({`EWP_OP_WRITE, 16'h0200, 8'h22, 16'h0}, 32);
    wait_idle();
    `TB_EQ("one_start", 1, starts - s0)
    `TB_EQ("first_addr", 11'h100, addr)
    `TB_EQ("latch_busy", 1'b0, status[1])
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    t_power_on();
    t_latch();
    t_refuse();
    t_status();
    t_bp();
    t_hw();
    t_busy();
    tally_and_finish();
  end
endmodule
